// >>> rtl/dpa_pkg.sv
/*
  Shared constants and types for the divider phase and output alignment block.
  Assumes one byte-wide register port and one clock, the channel divider input clock.
*/
package dpa_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_REGS = 15;
  localparam logic [9:0] ADDR_SOFT_RESET = 10'h000;
  localparam logic [9:0] ADDR_STATUS     = 10'h231;
  localparam logic [9:0] ADDR_UPDATE     = 10'h232;
  // Buffered registers, in index order: channel 3, channel 4, outputs, distribution control.
  localparam logic [9:0] REG_ADDR_TAB [0:NUM_REGS-1] = '{
    10'h199, 10'h19A, 10'h19B, 10'h19C, 10'h19D,
    10'h19E, 10'h19F, 10'h1A0, 10'h1A1, 10'h1A2,
    10'h140, 10'h141, 10'h142, 10'h143, 10'h230};
  localparam logic [3:0] IDX_NONE    = 4'hF;
  localparam int unsigned CH_REGS    = 5;   // Registers per channel.
  localparam int unsigned OFS_CNT1   = 0;   // Stage 1 low/high counts.
  localparam int unsigned OFS_PHASE  = 1;   // Phase offsets of both stages.
  localparam int unsigned OFS_CNT2   = 2;   // Stage 2 low/high counts.
  localparam int unsigned OFS_START  = 3;   // Start-high bits of both stages.
  localparam int unsigned OFS_EXCL   = 4;   // Exclude-from-alignment bit.
  localparam int unsigned IDX_OUT0   = 10;
  localparam int unsigned IDX_DIST   = 14;
  localparam logic [7:0] REG_DEFAULT = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned SOFT_RESET_BIT  = 2;
  localparam int unsigned SOFT_MIRROR_BIT = 5;
  localparam int unsigned SOFT_ALIGN_BIT  = 0;
  localparam int unsigned DIST_PD_BIT     = 1;
  localparam int unsigned UPDATE_BIT      = 0;
  localparam int unsigned EXCL_BIT        = 0;
  localparam int unsigned OUT_PD_BIT      = 0;
  localparam int unsigned OUT_CMOS_BIT    = 3;
  localparam int unsigned OUT_B_EN_BIT    = 4;
  localparam int unsigned OUT_POL_LSB     = 5;
  localparam int unsigned NIB             = 4;

  // ----------------------------------------------------------------------
  // Timing, in channel divider input cycles
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned ALIGN_LAT    = 14;
  localparam int unsigned EXTRA_CYC    = 1;
  localparam logic [3:0] WAIT_CH  = 4'(ALIGN_LAT + EXTRA_CYC - SYNC_STAGES);
  localparam logic [3:0] WAIT_VCO = 4'(ALIGN_LAT - SYNC_STAGES);
  localparam logic [5:0] PHASE_WRAP = 6'h10;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       start_high;
    logic [3:0] phase_offset;
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
  } dpa_stage_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } dpa_reg_req_t;

  typedef enum logic [1:0] {ALIGN_HOLD, ALIGN_WAIT, ALIGN_RUN} dpa_align_state_t;

endpackage

// >>> rtl/dpa_sync2.sv
/*
  Two flip-flop synchronizer for one level.
  Assumes the input is asynchronous to clk and idles at RST_VAL.
*/
`timescale 1ns/100ps
`default_nettype none
module dpa_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Level
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;

  // The first flop feeds only the second one.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dpa_div_stage.sv
/*
  One divider stage with coarse phase offset and static preset.
  Assumes tick marks one input-clock period of this stage and hold comes from clk logic.
*/
`timescale 1ns/100ps
`default_nettype none
module dpa_div_stage (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Control
  input  wire logic                    tick,
  input  wire logic                    hold,
  input  wire dpa_pkg::dpa_stage_cfg_t cfg,
  // Result
  output logic                         level,
  output logic                         rise
);
  import dpa_pkg::*;

  logic [5:0] phase_val;
  logic [5:0] delay_val;
  logic [4:0] cnt_reg;
  logic       waiting_reg;

  // Start-high weighs 16, the offset nibble weighs 8, 4, 2 and 1.
  assign phase_val = {1'b0, cfg.start_high, cfg.phase_offset};

  // Large phase values wrap into the low phase of the first period.
  always_comb begin
    if (phase_val < PHASE_WRAP) begin
      delay_val = phase_val;
    end else begin
      delay_val = phase_val - PHASE_WRAP + {2'b00, cfg.low_cnt} + 6'h01;
    end
  end

  // Period is high plus low plus two; while held, level is the preset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level       <= 1'b0;
      rise        <= 1'b0;
      cnt_reg     <= 5'h00;
      waiting_reg <= 1'b1;
    end else if (hold) begin
      level       <= cfg.start_high;
      rise        <= 1'b0;
      cnt_reg     <= delay_val[4:0];
      waiting_reg <= 1'b1;
    end else begin
      rise <= 1'b0;
      if (tick) begin
        if (cnt_reg != 5'h00) begin
          cnt_reg <= cnt_reg - 5'h01;
        end else if (waiting_reg || !level) begin
          waiting_reg <= 1'b0;
          level       <= 1'b1;
          rise        <= 1'b1;
          cnt_reg     <= {1'b0, cfg.high_cnt};
        end else begin
          level   <= 1'b0;
          cnt_reg <= {1'b0, cfg.low_cnt};
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dpa_align_top.sv
/*
  Divider phase offset and output alignment for two channel dividers and four
  LVDS/CMOS outputs, with the byte register file that configures them.
  Assumes clk is the channel divider input clock, the register port and the
  calibration flag come from logic on clk, and both pins are asynchronous.
*/
// How it works
// - Stage phase is start_high times sixteen plus the four-bit offset nibble.
// - Start, offset and count nibbles sit at fixed bits of fixed registers.
// - Phase up to fifteen delays that many periods, else minus sixteen plus low+1.
// - Alignment holds non-excluded outputs static, then releases them together.
// - A low pulse on the align request pin starts a manual alignment.
// - Setting then clearing soft align, soft reset or distribution power-down aligns.
// - Power-up runs an alignment automatically.
// - Releasing reset also ends in an alignment.
// - Leaving sleep through the sleep pin ends in an alignment.
// - Calibration holds the alignment request until it completes.
// - Clocking resumes fourteen to fifteen cycles after request release, plus one without the VCO divider.
// - The asynchronous request may add one cycle of uncertainty.
// - Latency is counted from the rising edge of the release.
// - Soft align changes act only after an update-all-registers write.
// - Start-high and offset set the held level and the phase after release.
// - Both outputs sharing a channel divider get the same alignment.
// - Excluded channels keep clocking and are not aligned.
// - In CMOS mode half A is on; half B is switched on its own.
// - One power-down bit turns off the driver or both CMOS halves.
// - A three-bit field selects the polarity of both CMOS halves.
// - Every reset loads defaults into staged and active registers at once.
// - Each stage divides by high count plus low count plus two.
`timescale 1ns/100ps
`default_nettype none
module dpa_align_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Device pins, asynchronous, active low
  input  wire logic                  align_request_pin_n,
  input  wire logic                  sleep_pin_n,
  // Internal status from logic on clk
  input  wire logic                  cal_busy,
  input  wire logic                  vco_div_used,
  // Register port
  input  wire dpa_pkg::dpa_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  // Output drivers
  output logic [3:0]                 out_a,
  output logic [3:0]                 out_a_en,
  output logic [3:0]                 out_b,
  output logic [3:0]                 out_b_en,
  output logic                       align_busy
);
  import dpa_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]       staged_mem [0:NUM_REGS-1];
  logic [7:0]       active_mem [0:NUM_REGS-1];
  logic [7:0]       soft_reset_reg;
  logic             soft_reset_on;
  logic             update_pulse;
  logic [3:0]       wr_idx;
  logic [3:0]       rd_idx;
  logic             pin_req_sync;
  logic             sleep_sync;
  logic             align_req;
  logic             dist_pd;
  dpa_align_state_t state_reg;
  logic [3:0]       wait_cnt_reg;
  logic             div_hold;
  logic [1:0]       ch_level;
  logic [3:0]       a_next;
  logic [3:0]       a_en_next;
  logic [3:0]       b_next;
  logic [3:0]       b_en_next;
  logic [7:0]       status_val;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------

  // Maps a byte address to its buffered register index, or IDX_NONE.
  function automatic logic [3:0] reg_index(input logic [9:0] addr);
    logic [3:0] idx;
    idx = IDX_NONE;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR_TAB[i] == addr) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Splits a channel's count, phase and start bytes into one stage's settings.
  // Bytes come in as arguments, so that callers in continuous assignments
  // see every update of the active copy.
  function automatic dpa_stage_cfg_t stage_cfg(input logic [7:0]  cnt,
                                               input logic [7:0]  pho,
                                               input logic [7:0]  sh,
                                               input int unsigned stg);
    dpa_stage_cfg_t c;
    c.start_high   = sh[stg];
    c.phase_offset = (stg == 0) ? pho[NIB-1:0] : pho[2*NIB-1:NIB];
    c.low_cnt      = cnt[2*NIB-1:NIB];
    c.high_cnt     = cnt[NIB-1:0];
    return c;
  endfunction

  assign wr_idx = reg_index(reg_req.addr);
  assign rd_idx = wr_idx;

  // ----------------------------------------------------------------------
  // Pin synchronizers
  // ----------------------------------------------------------------------

  // The request pin is asynchronous to every internal edge, so the phase
  // of its release is only known to within one input cycle.
  dpa_sync2 #(
    .RST_VAL (1'b1)
  ) u_sync_align (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (align_request_pin_n),
    .dout  (pin_req_sync)
  );

  dpa_sync2 #(
    .RST_VAL (1'b1)
  ) u_sync_sleep (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (sleep_pin_n),
    .dout  (sleep_sync)
  );

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------

  // The soft reset byte needs no update and survives its own reset, so
  // software can hold it set and later clear it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      soft_reset_reg <= REG_DEFAULT;
    end else if (reg_req.wr && reg_req.addr == ADDR_SOFT_RESET) begin
      soft_reset_reg <= reg_req.wdata;
    end
  end

  assign soft_reset_on = soft_reset_reg[SOFT_RESET_BIT] | soft_reset_reg[SOFT_MIRROR_BIT];
  assign update_pulse  = reg_req.wr && reg_req.addr == ADDR_UPDATE && reg_req.wdata[UPDATE_BIT];

  // Writes land in the staged copy; an update copies all of it to the
  // active copy in one cycle, so a set of related fields changes together.
  always_ff @(posedge clk) begin
    if (!rst_b || soft_reset_on) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        staged_mem[i] <= REG_DEFAULT;
        active_mem[i] <= REG_DEFAULT;
      end
    end else begin
      if (reg_req.wr && wr_idx != IDX_NONE) begin
        staged_mem[wr_idx] <= reg_req.wdata;
      end
      if (update_pulse) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          active_mem[i] <= staged_mem[i];
        end
      end
    end
  end

  // Live status: alignment phase, channel levels, calibration and sleep.
  assign status_val = {3'b000, ~sleep_sync, cal_busy, ch_level,
                       (state_reg != ALIGN_RUN)};

  // Reads answer one cycle later; unmapped addresses read as zero.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (!reg_req.rd) begin
        reg_rdata <= 8'h00;
      end else if (rd_idx != IDX_NONE) begin
        reg_rdata <= staged_mem[rd_idx];
      end else if (reg_req.addr == ADDR_SOFT_RESET) begin
        reg_rdata <= soft_reset_reg;
      end else if (reg_req.addr == ADDR_STATUS) begin
        reg_rdata <= status_val;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Alignment request and sequencing
  // ----------------------------------------------------------------------

  assign dist_pd = active_mem[IDX_DIST][DIST_PD_BIT];

  // Every source holds the request while active; alignment happens when
  // the last of them lets go.
  assign align_req = ~pin_req_sync
                   | active_mem[IDX_DIST][SOFT_ALIGN_BIT]
                   | dist_pd
                   | soft_reset_on
                   | ~sleep_sync
                   | cal_busy;

  // Reset parks the sequencer in hold, so every reset and power-up ends
  // in a release through the same path as a manual request.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg    <= ALIGN_HOLD;
      wait_cnt_reg <= WAIT_CH;
    end else begin
      case (state_reg)
        ALIGN_HOLD: begin
          if (!align_req) begin
            state_reg    <= ALIGN_WAIT;
            wait_cnt_reg <= vco_div_used ? WAIT_VCO : WAIT_CH;
          end
        end
        ALIGN_WAIT: begin
          if (align_req) begin
            state_reg <= ALIGN_HOLD;
          end else if (wait_cnt_reg == 4'h0) begin
            state_reg <= ALIGN_RUN;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 4'h1;
          end
        end
        ALIGN_RUN: begin
          if (align_req) begin
            state_reg <= ALIGN_HOLD;
          end
        end
        default: begin
          state_reg <= ALIGN_HOLD;
        end
      endcase
    end
  end

  // All non-excluded channels leave hold on the same edge.
  assign div_hold = (state_reg != ALIGN_RUN);

  // ----------------------------------------------------------------------
  // Channel dividers
  // ----------------------------------------------------------------------

  // Stage two advances on each rising edge of stage one, one cycle late;
  // that lag is the same on every channel, so relative phase holds.
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic           ch_hold;
    logic           s1_rise;
    logic [7:0]     cnt1_byte;
    logic [7:0]     cnt2_byte;
    logic [7:0]     phase_byte;
    logic [7:0]     start_byte;
    dpa_stage_cfg_t s1_cfg;
    dpa_stage_cfg_t s2_cfg;

    assign ch_hold = div_hold & ~active_mem[ch * CH_REGS + OFS_EXCL][EXCL_BIT];

    // Both stages take their settings from the active copy.
    assign cnt1_byte  = active_mem[ch * CH_REGS + OFS_CNT1];
    assign cnt2_byte  = active_mem[ch * CH_REGS + OFS_CNT2];
    assign phase_byte = active_mem[ch * CH_REGS + OFS_PHASE];
    assign start_byte = active_mem[ch * CH_REGS + OFS_START];
    assign s1_cfg     = stage_cfg(cnt1_byte, phase_byte, start_byte, 0);
    assign s2_cfg     = stage_cfg(cnt2_byte, phase_byte, start_byte, 1);

    dpa_div_stage u_stage1 (
      .clk   (clk),
      .rst_b (rst_b),
      .tick  (1'b1),
      .hold  (ch_hold),
      .cfg   (s1_cfg),
      .level (),
      .rise  (s1_rise)
    );

    dpa_div_stage u_stage2 (
      .clk   (clk),
      .rst_b (rst_b),
      .tick  (s1_rise),
      .hold  (ch_hold),
      .cfg   (s2_cfg),
      .level (ch_level[ch]),
      .rise  ()
    );
  end

  // ----------------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------------

  // Outputs 0 and 1 follow channel 0, outputs 2 and 3 follow channel 1.
  // Polarity field: bit 0 inverts A, bit 1 inverts B in CMOS mode only, bit 2 inverts both.
  for (genvar o = 0; o < 4; o++) begin : g_out
    logic [7:0] cfg;
    logic [2:0] pol;
    logic       lvl;
    logic       off;

    assign cfg = active_mem[IDX_OUT0 + o];
    assign pol = cfg[OUT_POL_LSB +: 3];
    assign lvl = ch_level[o / 2];
    assign off = cfg[OUT_PD_BIT] | dist_pd | ~sleep_sync;

    assign a_next[o]    = lvl ^ pol[0] ^ pol[2];
    assign b_next[o]    = cfg[OUT_CMOS_BIT] ? (lvl ^ pol[1] ^ pol[2])
                                            : ~(lvl ^ pol[0] ^ pol[2]);
    assign a_en_next[o] = ~off;
    assign b_en_next[o] = ~off & (~cfg[OUT_CMOS_BIT] | cfg[OUT_B_EN_BIT]);
  end

  // Every output leaves from a flop, which costs one cycle of latency
  // but keeps glitches from the decode off the pins.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_a      <= 4'h0;
      out_a_en   <= 4'h0;
      out_b      <= 4'h0;
      out_b_en   <= 4'h0;
      align_busy <= 1'b1;
    end else begin
      out_a      <= a_next;
      out_a_en   <= a_en_next;
      out_b      <= b_next;
      out_b_en   <= b_en_next;
      align_busy <= div_hold;
    end
  end

endmodule
`default_nettype wire

// >>> test/dpa_align_top_properties.sv
/*
  Checker of the alignment block's ports.
  Assumes the bench drives pins off the falling edge of clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dpa_align_props (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // Stimulus seen at the ports
  input wire logic                  align_request_pin_n,
  input wire logic                  sleep_pin_n,
  input wire logic                  cal_busy,
  input wire dpa_pkg::dpa_reg_req_t reg_req,
  // Answers
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_rvalid,
  input wire logic [3:0]            out_a_en,
  input wire logic [3:0]            out_b_en,
  input wire logic                  align_busy
);
  import dpa_pkg::*;
  // --------------------------------------------------------------
  // Properties, all on clk
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A read answers exactly one cycle later and only then.
  rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("read answer without a read");
  rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  // Pins pass two flops, so five low samples must hold the outputs.
  pin_hold_a: assert property ((!align_request_pin_n)[*5] |-> align_busy)
    else $error("request pin did not hold");
  release_early_a: assert property ($rose(align_request_pin_n) |-> align_busy[*8])
    else $error("release too early");
  release_late_a: assert property ($rose(align_request_pin_n) && sleep_pin_n && !cal_busy
    |-> ##[15:20] !align_busy)
    else $error("release too late");
  cal_hold_a: assert property (cal_busy[*3] |-> align_busy)
    else $error("calibration did not hold");
  sleep_off_a: assert property ((!sleep_pin_n)[*5] |-> out_a_en == 4'h0 && out_b_en == 4'h0)
    else $error("outputs on while asleep");
  // Reset itself must be watched, so this one is never disabled.
  reset_state_a: assert property (disable iff (1'b0)
    !rst_b |=> align_busy && out_a_en == 4'h0)
    else $error("reset state wrong");
  cover property ($rose(align_request_pin_n));
  cover property ($fell(cal_busy));
  cover property ($fell(sleep_pin_n));
  cover property (reg_rvalid);
endmodule
bind dpa_align_top dpa_align_props props_u (
  .clk(clk), .rst_b(rst_b), .align_request_pin_n(align_request_pin_n),
  .sleep_pin_n(sleep_pin_n), .cal_busy(cal_busy), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .out_a_en(out_a_en),
  .out_b_en(out_b_en), .align_busy(align_busy));
`default_nettype wire

// >>> test/dpa_host_model.sv
/*
  Host controller model: request pin and register port.
  Assumes strobes launched at falling edges are taken at the next rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module dpa_host_model (
  // Clock and answers
  input  wire logic            clk,
  input  wire logic [7:0]      reg_rdata,
  input  wire logic            reg_rvalid,
  // Requests
  output var logic             align_request_pin_n,
  output var dpa_pkg::dpa_reg_req_t reg_req
);
  import dpa_pkg::*;
  // Idle: pin released high, no strobe.
  initial begin
    align_request_pin_n = 1'b1;
    reg_req = '0;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask
  // Read data stands one cycle only, so it is taken at that cycle.
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    d = reg_rdata;
    v = reg_rvalid;
    reg_req.rd = 1'b0;
  endtask
  task automatic upd();
    wr(ADDR_UPDATE, 8'h01);
  endtask
  task automatic pin(input logic v);
    @(negedge clk);
    align_request_pin_n = v;
  endtask
  task automatic pulse(input int n);
    pin(1'b0);
    repeat (n) @(negedge clk);
    align_request_pin_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> test/dpa_align_top_tb.sv
/*
  Self-checking bench of the alignment block.
  Assumes the host model and the bound checker sit beside the design.
*/
`timescale 1ns/100ps
`default_nettype none
module dpa_align_top_tb;
  import dpa_pkg::*;
  logic clk, rst_b, sleep_pin_n, cal_busy, vco_div_used, align_request_pin_n, reg_rvalid;
  logic [7:0] reg_rdata, c1, c2, ph, sh, r, v;
  logic [3:0] out_a, out_a_en, out_b, out_b_en;
  logic align_busy, pv;
  dpa_reg_req_t reg_req;
  int miscompares, samples_checked, seed, cyc, t0, t1, p, d, tg;
  logic [9:0] sa [0:2] = '{ADDR_SOFT_RESET, 10'h230, 10'h230};
  logic [7:0] sd [0:2] = '{8'h24, 8'h01, 8'h02};
  dpa_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .align_request_pin_n(align_request_pin_n), .reg_req(reg_req));
  dpa_align_top dut_u (.clk(clk), .rst_b(rst_b), .align_request_pin_n(align_request_pin_n),
    .sleep_pin_n(sleep_pin_n), .cal_busy(cal_busy), .vco_div_used(vco_div_used),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .out_a(out_a),
    .out_a_en(out_a_en), .out_b(out_b), .out_b_en(out_b_en), .align_busy(align_busy));
  // Clock of 4 ns and a cycle count for edge timing.
  always #2 clk = ~clk;
  always @(posedge clk) cyc++;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] x;
    logic y;
    host_u.rd(a, x, y);
    chk(y, 1'b1);
    chk(x, e);
  endtask
  // Bounded wait so a stuck hold is reported instead of hanging.
  task automatic wait_idle();
    for (int k = 0; k < 40 && align_busy !== 1'b0; k++) @(negedge clk);
    chk(align_busy, 1'b0);
  endtask
  task automatic rise(input int i, output int t);
    logic q;
    q = out_a[i];
    for (int k = 0; k < 600; k++) begin
      @(negedge clk);
      chk(out_a[1], out_a[0]);
      if (!q && out_a[i]) begin
        t = cyc;
        return;
      end
      q = out_a[i];
    end
    chk(1'b0, 1'b1);
  endtask
  function automatic int dly(input logic [4:0] f, input int m);
    return (f <= 5'd15) ? int'(f) : int'(f) - 16 + m + 1;
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog, well past the few thousand cycles the run needs.
  initial begin
    #80000;
    miscompares++;
    print_verdict();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {clk, rst_b, cal_busy, vco_div_used, cyc} = '0;
    sleep_pin_n = 1'b1;
    seed = 2;
    repeat (3) @(negedge clk);
    chk(align_busy, 1'b1);
    rst_b = 1'b1;
    wait_idle();
    for (int i = 0; i < NUM_REGS; i++) rchk(REG_ADDR_TAB[i], REG_DEFAULT);
    rchk(10'h3FF, 8'h00);
    // Random counts and phases; channel 4 is the zero-phase reference.
    for (int n = 0; n < 4; n++) begin
      c1 = $random(seed) & 8'h33;
      c2 = $random(seed) & 8'h33;
      ph = $random(seed);
      sh = $random(seed) & 8'h03;
      host_u.wr(10'h199, c1);
      host_u.wr(10'h19A, ph);
      host_u.wr(10'h19B, c2);
      host_u.wr(10'h19C, sh);
      host_u.wr(10'h19E, c1);
      host_u.wr(10'h19F, 8'h00);
      host_u.wr(10'h1A0, c2);
      host_u.wr(10'h1A1, 8'h00);
      rchk(10'h19A, ph);
      host_u.upd();
      vco_div_used = n[0];
      host_u.pulse(5);
      wait_idle();
      t0 = c1[3:0] + c1[7:4] + 2;
      p = t0 * (c2[3:0] + c2[7:4] + 2);
      d = dly({sh[0], ph[3:0]}, c1[7:4]) + dly({sh[1], ph[7:4]}, c2[7:4]) * t0;
      rise(0, t0);
      rise(0, t1);
      chk(8'(t1 - t0), 8'(p));
      rise(2, t0);
      rise(0, t1);
      chk(8'((t1 - t0) % p), 8'(d % p));
    end
    // Channel 3 excluded keeps running; channel 4 holds its start level.
    host_u.wr(10'h19D, 8'h01);
    host_u.wr(10'h1A1, 8'h02);
    host_u.upd();
    host_u.pin(1'b0);
    repeat (6) @(negedge clk);
    tg = 0;
    pv = out_a[0];
    repeat (40) begin
      @(negedge clk);
      tg += int'(out_a[0] !== pv);
      pv = out_a[0];
      chk(out_a[2], 1'b1);
    end
    chk(tg > 0, 1'b1);
    host_u.pin(1'b1);
    wait_idle();
    // Soft reset, soft align and distribution power-down each align.
    for (int k = 0; k < 3; k++) begin
      host_u.wr(sa[k], sd[k]);
      repeat (4) @(negedge clk);
      if (k > 0) begin
        chk(align_busy, 1'b0);
        host_u.upd();
        repeat (4) @(negedge clk);
      end
      chk(align_busy, 1'b1);
      if (k == 0) rchk(10'h199, 8'h00);
      if (k == 2) chk(out_a_en, 4'h0);
      host_u.wr(sa[k], 8'h00);
      if (k > 0) begin
        repeat (4) @(negedge clk);
        chk(align_busy, 1'b1);
        host_u.upd();
      end
      wait_idle();
    end
    // Output modes, enables and polarity on output 0.
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      v = {k[2:0], r[4:3], 2'b00, r[0]};
      host_u.wr(10'h140, v);
      host_u.upd();
      repeat (3) @(negedge clk);
      chk(out_a_en[0], !v[0]);
      chk(out_b_en[0], !v[0] && (v[4] || !v[3]));
      if (!v[0] && (v[4] || !v[3])) chk(out_a[0] ^ out_b[0], v[3] ? v[5] ^ v[6] : 1'b1);
    end
    cal_busy = 1'b1;
    repeat (6) @(negedge clk);
    chk(align_busy, 1'b1);
    cal_busy = 1'b0;
    wait_idle();
    sleep_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(align_busy, 1'b1);
    sleep_pin_n = 1'b1;
    wait_idle();
    host_u.wr(10'h19E, 8'h55);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    wait_idle();
    rchk(10'h19E, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
